// ==== hdl/prog_port_pkg.sv ====
// constants for the parallel programming port
package prog_port_pkg;
    localparam int          CLK_MHZ        = 250;
    localparam int          DATA_W         = 8;
    localparam logic [7:0]  CMD_NOP        = 8'h00;
    localparam logic [7:0]  CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0]  CMD_WR_FUSE    = 8'h40;
    localparam logic [7:0]  CMD_WR_LOCK    = 8'h20;
    localparam logic [7:0]  CMD_WR_FLASH   = 8'h10;
    localparam logic [7:0]  CMD_WR_EEPROM  = 8'h11;
    localparam logic [7:0]  CMD_RD_SIG     = 8'h08;
    localparam logic [7:0]  CMD_RD_FUSE    = 8'h04;
    localparam logic [7:0]  CMD_RD_FLASH   = 8'h02;
    localparam logic [7:0]  CMD_RD_EEPROM  = 8'h03;
    localparam logic [1:0]  ACT_ADDR       = 2'h0;
    localparam logic [1:0]  ACT_DATA       = 2'h1;
    localparam logic [1:0]  ACT_CMD        = 2'h2;
    localparam int          EE_DEPTH       = 128;
    localparam int          EE_AW          = 7;
    localparam int          FLASH_DEPTH    = 1024;
    localparam int          FLASH_AW       = 10;
    localparam int          PAGE_DEPTH     = 4;
    localparam int          PAGE_AW        = 2;
    localparam logic [7:0]  ERASED_BYTE    = 8'hff;
    localparam logic [7:0]  FUSE_LO_RST    = 8'hff;
    localparam logic [7:0]  FUSE_HI_RST    = 8'hff;
    localparam logic [7:0]  FUSE_EXT_RST   = 8'hff;
    localparam logic [7:0]  LOCK_RST       = 8'hff;
    // lock bits one and two sit in bits 0 and 1, boot lock bits above
    localparam int          LOCK_ONE_BIT   = 0;
    localparam int          LOCK_TWO_BIT   = 1;
    localparam logic [7:0]  BOOT_LOCK_MASK = 8'hfc;
    localparam int          SIG_ADDR_MAX   = 2;
    // write busy time, in microseconds, 4 ms, inside 3.7 .. 4.5 ms
    localparam int          WRITE_BUSY_US  = 4000;
    localparam int          ERASE_BUSY_US  = 8000;
    localparam int          WRITE_BUSY_CYC = WRITE_BUSY_US * CLK_MHZ;
    localparam int          ERASE_BUSY_CYC = ERASE_BUSY_US * CLK_MHZ;
    localparam int          BUSY_W         = 22;
endpackage

// ==== hdl/strobe_edge.sv ====
// one-cycle pulse on a chosen edge of a synchronous strobe input
`timescale 1ns/1ps
module strobe_edge
#(
    parameter bit RISING = 1'b1
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic strobe,
    output logic      pulse
);
    logic last;
    logic next_last;

    always_comb
    begin
        next_last = strobe;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            last <= RISING ? 1'b1 : 1'b0;
        else if (clk_en)
            last <= next_last;
    end

    assign pulse = clk_en && (RISING ? (strobe && !last) : (!strobe && last));
endmodule

// ==== hdl/parallel_nvm_programming_port.sv ====
// parallel high-voltage programming port: command decode, memories, busy timer
`timescale 1ns/1ps
module parallel_nvm_programming_port
    import prog_port_pkg::*;
#(
    parameter logic [7:0] SIG_BYTE0 = 8'h11,  // arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h22,  // arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h33,  // arbitrary value
    parameter logic [7:0] CAL_BYTE  = 8'h5a,  // arbitrary value
    parameter int         WRITE_CYC = WRITE_BUSY_CYC,
    parameter int         ERASE_CYC = ERASE_BUSY_CYC
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        load_strobe,
    input  wire logic        action_select_hi,
    input  wire logic        action_select_lo,
    input  wire logic        byte_select_a,
    input  wire logic        byte_select_b,
    input  wire logic        write_strobe_n,
    input  wire logic        output_enable_n,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             ready_busy
);
    typedef enum {ST_IDLE, ST_BUSY} state_t;

    logic [7:0]  flash_lo [FLASH_DEPTH];
    logic [7:0]  flash_hi [FLASH_DEPTH];
    logic [7:0]  eeprom   [EE_DEPTH];
    logic [7:0]  page_buf [PAGE_DEPTH];
    logic [PAGE_DEPTH-1:0] page_valid;

    state_t      state, next_state;
    logic [7:0]  cmd, next_cmd;
    logic [7:0]  addr_lo, next_addr_lo;
    logic [7:0]  addr_hi, next_addr_hi;
    logic [7:0]  data_lo, next_data_lo;
    logic [7:0]  data_hi, next_data_hi;
    logic [7:0]  fuse_lo, next_fuse_lo;
    logic [7:0]  fuse_hi, next_fuse_hi;
    logic [7:0]  fuse_ext, next_fuse_ext;
    logic [7:0]  lock, next_lock;
    logic [BUSY_W-1:0] busy_cnt, next_busy_cnt;
    logic [7:0]  next_data_out;
    logic        next_data_oe;

    logic        load_pulse;
    logic        wr_pulse;
    logic [1:0]  action;
    logic [EE_AW-1:0]    ee_addr;
    logic [FLASH_AW-1:0] fl_addr;
    logic                mode3;

    strobe_edge #(.RISING(1'b1)) u_load_edge
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .strobe  (load_strobe),
        .pulse   (load_pulse)
    );

    strobe_edge #(.RISING(1'b0)) u_write_edge
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .strobe  (write_strobe_n),
        .pulse   (wr_pulse)
    );

    assign action  = {action_select_hi, action_select_lo};
    assign ee_addr = addr_lo[EE_AW-1:0];
    assign fl_addr = {addr_hi[FLASH_AW-9:0], addr_lo};
    assign mode3   = !lock[LOCK_ONE_BIT] && !lock[LOCK_TWO_BIT];

    // register loads, nonvolatile updates and busy timer
    always_comb
    begin
        next_state    = state;
        next_cmd      = cmd;
        next_addr_lo  = addr_lo;
        next_addr_hi  = addr_hi;
        next_data_lo  = data_lo;
        next_data_hi  = data_hi;
        next_fuse_lo  = fuse_lo;
        next_fuse_hi  = fuse_hi;
        next_fuse_ext = fuse_ext;
        next_lock     = lock;
        next_busy_cnt = busy_cnt;
        case (state)
            ST_IDLE:
            begin
                if (load_pulse)
                begin
                    if (action == ACT_ADDR)
                    begin
                        if (byte_select_a)
                            next_addr_hi = data_in;
                        else
                            next_addr_lo = data_in;
                    end
                    else if (action == ACT_DATA)
                    begin
                        if (byte_select_a)
                            next_data_hi = data_in;
                        else
                            next_data_lo = data_in;
                    end
                    else if (action == ACT_CMD)
                        next_cmd = data_in;
                end
                if (wr_pulse)
                begin
                    if (cmd == CMD_CHIP_ERASE)
                    begin
                        next_state    = ST_BUSY;
                        next_busy_cnt = BUSY_W'(ERASE_CYC - 1);
                        next_lock     = LOCK_RST;
                    end
                    else if (cmd == CMD_WR_FUSE || cmd == CMD_WR_LOCK || cmd == CMD_WR_EEPROM
                             || cmd == CMD_WR_FLASH)
                    begin
                        next_state    = ST_BUSY;
                        next_busy_cnt = BUSY_W'(WRITE_CYC - 1);
                    end
                    // fuse bits take data low byte
                    if (cmd == CMD_WR_FUSE)
                    begin
                        if (byte_select_a && !byte_select_b)
                            next_fuse_hi = data_lo;
                        else if (!byte_select_a && byte_select_b)
                            next_fuse_ext = data_lo;
                        else if (!byte_select_a && !byte_select_b)
                            next_fuse_lo = data_lo;
                    end
                    // lock program, boot bits held in mode 3
                    if (cmd == CMD_WR_LOCK)
                        next_lock = lock & (mode3 ? (data_lo | BOOT_LOCK_MASK) : data_lo);
                end
            end
            ST_BUSY:
            begin
                if (busy_cnt == '0)
                    next_state = ST_IDLE;
                else
                    next_busy_cnt = busy_cnt - 1'b1;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state    <= ST_IDLE;
            cmd      <= CMD_NOP;
            addr_lo  <= '0;
            addr_hi  <= '0;
            data_lo  <= '0;
            data_hi  <= '0;
            fuse_lo  <= FUSE_LO_RST;
            fuse_hi  <= FUSE_HI_RST;
            fuse_ext <= FUSE_EXT_RST;
            lock     <= LOCK_RST;
            busy_cnt <= '0;
        end
        else if (clk_en)
        begin
            state    <= next_state;
            cmd      <= next_cmd;
            addr_lo  <= next_addr_lo;
            addr_hi  <= next_addr_hi;
            data_lo  <= next_data_lo;
            data_hi  <= next_data_hi;
            fuse_lo  <= next_fuse_lo;
            fuse_hi  <= next_fuse_hi;
            fuse_ext <= next_fuse_ext;
            lock     <= next_lock;
            busy_cnt <= next_busy_cnt;
        end
    end

    // memory arrays: page buffer, eeprom and flash contents (no reset)
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            page_valid <= '0;
        else if (clk_en && state == ST_IDLE)
        begin
            // page buffer filled by data loads
            if (load_pulse && action == ACT_DATA && !byte_select_a && cmd == CMD_WR_EEPROM)
            begin
                page_buf[next_addr_lo[PAGE_AW-1:0]]   <= data_in;
                page_valid[next_addr_lo[PAGE_AW-1:0]] <= 1'b1;
            end
            // page write on strobe with select a low
            if (wr_pulse && cmd == CMD_WR_EEPROM && !byte_select_a)
            begin
                for (int i = 0; i < PAGE_DEPTH; i++)
                    if (page_valid[i])
                        eeprom[{ee_addr[EE_AW-1:PAGE_AW], PAGE_AW'(i)}] <= page_buf[i];
                page_valid <= '0;
            end
            if (wr_pulse && cmd == CMD_WR_FLASH)
            begin
                flash_lo[fl_addr] <= data_lo;
                flash_hi[fl_addr] <= data_hi;
            end
            if (wr_pulse && cmd == CMD_CHIP_ERASE)
            begin
                for (int j = 0; j < EE_DEPTH; j++)
                    eeprom[j] <= ERASED_BYTE;
                for (int k = 0; k < FLASH_DEPTH; k++)
                begin
                    flash_lo[k] <= ERASED_BYTE;
                    flash_hi[k] <= ERASED_BYTE;
                end
            end
        end
    end

    // read data mux and bus drive
    always_comb
    begin
        next_data_out = '0;
        // drive only with output enable low
        next_data_oe  = !output_enable_n;
        case (cmd)
            CMD_RD_FLASH:
                next_data_out = byte_select_a ? flash_hi[fl_addr] : flash_lo[fl_addr];
            CMD_RD_EEPROM:
                next_data_out = byte_select_a ? 8'h00 : eeprom[ee_addr];
            // fuse and lock by byte selects
            CMD_RD_FUSE:
                case ({byte_select_b, byte_select_a})
                    2'h0:    next_data_out = fuse_lo;
                    2'h3:    next_data_out = fuse_hi;
                    2'h2:    next_data_out = fuse_ext;
                    default: next_data_out = lock;
                endcase
            CMD_RD_SIG:
                if (byte_select_a)
                    next_data_out = (addr_lo == 8'h00) ? CAL_BYTE : 8'h00;
                else if (addr_lo == 8'h00)
                    next_data_out = SIG_BYTE0;
                else if (addr_lo == 8'h01)
                    next_data_out = SIG_BYTE1;
                else if (addr_lo == 8'(SIG_ADDR_MAX))
                    next_data_out = SIG_BYTE2;
            default:
                next_data_out = '0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            data_out   <= '0;
            data_oe    <= 1'b0;
            ready_busy <= 1'b1;
        end
        else if (clk_en)
        begin
            data_out   <= next_data_out;
            data_oe    <= next_data_oe;
            ready_busy <= (next_state == ST_IDLE);
        end
    end

    // ready drops right after the chip erase strobe edge
    a_busy_on_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr_pulse && state == ST_IDLE && cmd == CMD_CHIP_ERASE |=> !ready_busy)
        else $error("ready not dropped after erase strobe");
    // bus released when output enable high
    a_bus_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && output_enable_n |=> !data_oe)
        else $error("bus driven with output enable high");
    // lock never rises except by erase
    a_lock_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cmd != CMD_CHIP_ERASE |=> (lock & ~$past(lock)) == 8'h00)
        else $error("lock bit cleared without erase");
    a_cmd_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && load_pulse && state == ST_IDLE && action == ACT_CMD |=> cmd == $past(data_in))
        else $error("command byte not latched");
    a_addr_hi_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && load_pulse && state == ST_IDLE && action == ACT_ADDR && byte_select_a
        |=> addr_hi == $past(data_in))
        else $error("high address byte not latched");
    a_fuse_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cmd == CMD_RD_FUSE && !byte_select_a && !byte_select_b |=> data_out == $past(fuse_lo))
        else $error("fuse low readback wrong");
endmodule

// ==== bench/hv_programmer.sv ====
// programmer model that drives the parallel programming port
`timescale 1ns/1ps
module hv_programmer
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       ready_busy,
    output logic            load_strobe,
    output logic            action_select_hi,
    output logic            action_select_lo,
    output logic            byte_select_a,
    output logic            byte_select_b,
    output logic            write_strobe_n,
    output logic            output_enable_n,
    output logic [7:0]      data_in
);
    logic [7:0] drv;
    // a released bus shows the last value, or its inverse while output enable is low and the port not yet driving
    assign data_in = data_oe ? data_out : (output_enable_n ? drv : ~drv);
    initial
    begin
        drv = 8'h00;
        load_strobe = 1'b0;
        {action_select_hi, action_select_lo} = 2'h3;
        byte_select_a = 1'b0;
        byte_select_b = 1'b0;
        write_strobe_n = 1'b1;
        output_enable_n = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic load(input logic [1:0] act, input logic bsa, input logic [7:0] d);
        {action_select_hi, action_select_lo} = act;
        byte_select_a = bsa;
        drv = d;
        step(1);
        load_strobe = 1'b1;
        step(1);
        load_strobe = 1'b0;
        step(1);
    endtask
    task automatic pulse(input logic bsa, input logic bsb, output int busy);
        byte_select_a = bsa;
        byte_select_b = bsb;
        step(1);
        write_strobe_n = 1'b0;
        step(1);
        write_strobe_n = 1'b1;
        step(1);
        // the edge that took the strobe already began the busy time
        busy = 1;
        while (ready_busy !== 1'b1 && busy < 200)
        begin
            busy++;
            step(1);
        end
        byte_select_a = 1'b0;
        byte_select_b = 1'b0;
    endtask
    task automatic read(input logic bsa, input logic bsb, output logic [7:0] q);
        byte_select_a = bsa;
        byte_select_b = bsb;
        output_enable_n = 1'b0;
        step(3);
        q = data_in;
        output_enable_n = 1'b1;
        step(2);
    endtask
endmodule

// ==== bench/test_parallel_nvm_programming_port.sv ====
// self-checking bench for the parallel programming port
`timescale 1ns/1ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("mismatch %0t %s got %h exp %h", $time, m, g, e); end end
module test_parallel_nvm_programming_port
    import prog_port_pkg::*;
;
    localparam int         WCYC = 8;
    localparam int         ECYC = 16;
    // signature and calibration values are arbitrary
    localparam logic [7:0] SIG [3] = '{8'h3c, 8'hc3, 8'h96};
    localparam logic [7:0] CAL     = 8'ha5;
    localparam logic [7:0] LKD [4] = '{8'hfe, 8'hff, 8'hfc, 8'h00};
    logic       ref_clk;
    logic       rst_n;
    logic       clk_en;
    logic       load_strobe;
    logic       action_select_hi;
    logic       action_select_lo;
    logic       byte_select_a;
    logic       byte_select_b;
    logic       write_strobe_n;
    logic       output_enable_n;
    logic [7:0] data_in;
    logic [7:0] data_out;
    logic       data_oe;
    logic       ready_busy;
    int         err_count;
    int         samples_checked;
    int         busy;
    int         i;
    logic [7:0] q;
    logic [7:0] base;
    logic [7:0] lock;
    logic [7:0] page [4];
    logic [7:0] fuse [3];
    logic [9:0] faddr;
    logic [15:0] fw;

    parallel_nvm_programming_port #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]),
        .CAL_BYTE(CAL), .WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .load_strobe(load_strobe), .action_select_hi(action_select_hi),
        .action_select_lo(action_select_lo), .byte_select_a(byte_select_a), .byte_select_b(byte_select_b),
        .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .ready_busy(ready_busy));
    hv_programmer u_prog (.ref_clk(ref_clk), .data_out(data_out), .data_oe(data_oe), .ready_busy(ready_busy),
        .load_strobe(load_strobe), .action_select_hi(action_select_hi), .action_select_lo(action_select_lo),
        .byte_select_a(byte_select_a), .byte_select_b(byte_select_b), .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n), .data_in(data_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // lock bits only ever go to programmed; mode 3 freezes the boot bits
    function automatic logic [7:0] lock_after(input logic [7:0] old, input logic [7:0] d);
        if (old[1:0] == 2'b00)
            return {old[7:2], old[1:0] & d[1:0]};
        return old & d;
    endfunction

    task automatic chk_busy(input int n, input int cyc);
        `CHK(n inside {[cyc:cyc + 2]}, 1'b1, "busy length")
        if (n >= 200)
            conclude();
    endtask

    task automatic note(input string s);
        $display("test done: %s", s);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        err_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        void'($urandom(96785));
        repeat (2) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        `CHK(ready_busy, 1'b1, "ready after reset")
        `CHK(data_oe, 1'b0, "bus released after reset")
        base = 8'(($urandom % 32) * 4);
        u_prog.load(ACT_CMD, 1'b0, CMD_WR_EEPROM);
        u_prog.load(ACT_ADDR, 1'b1, 8'h00);
        for (i = 0; i < PAGE_DEPTH; i++)
        begin
            page[i] = 8'($urandom);
            u_prog.load(ACT_ADDR, 1'b0, base + 8'(i));
            u_prog.load(ACT_DATA, 1'b0, page[i]);
        end
        u_prog.pulse(1'b0, 1'b0, busy);
        chk_busy(busy, WCYC);
        u_prog.load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
        for (i = 0; i < PAGE_DEPTH; i++)
        begin
            u_prog.load(ACT_ADDR, 1'b0, base + 8'(i));
            u_prog.read(1'b0, 1'b0, q);
            `CHK(q, page[i], "eeprom byte")
        end
        note("eeprom page");
        faddr = 10'($urandom);
        fw = 16'($urandom);
        u_prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
        u_prog.load(ACT_ADDR, 1'b0, faddr[7:0]);
        u_prog.load(ACT_DATA, 1'b0, fw[7:0]);
        u_prog.load(ACT_DATA, 1'b1, fw[15:8]);
        u_prog.load(ACT_ADDR, 1'b1, {6'h00, faddr[9:8]});
        u_prog.pulse(1'b0, 1'b0, busy);
        chk_busy(busy, WCYC);
        u_prog.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
        u_prog.read(1'b0, 1'b0, q);
        `CHK(q, fw[7:0], "flash low byte")
        u_prog.read(1'b1, 1'b0, q);
        `CHK(q, fw[15:8], "flash high byte")
        note("flash word");
        for (i = 0; i < 3; i++)
        begin
            fuse[i] = 8'($urandom);
            u_prog.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
            u_prog.load(ACT_DATA, 1'b0, fuse[i]);
            u_prog.pulse(i == 1, i == 2, busy);
            chk_busy(busy, WCYC);
        end
        u_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        for (i = 0; i < 3; i++)
        begin
            u_prog.read(i == 1, i != 0, q);
            `CHK(q, fuse[i], "fuse byte")
        end
        note("fuses");
        lock = LOCK_RST;
        for (i = 0; i < 4; i++)
        begin
            u_prog.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
            u_prog.load(ACT_DATA, 1'b0, LKD[i]);
            u_prog.pulse(1'b0, 1'b0, busy);
            chk_busy(busy, WCYC);
            lock = lock_after(lock, LKD[i]);
            u_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
            u_prog.read(1'b1, 1'b0, q);
            `CHK(q, lock, "lock byte")
        end
        note("lock bits");
        u_prog.load(ACT_CMD, 1'b0, CMD_CHIP_ERASE);
        u_prog.pulse(1'b0, 1'b0, busy);
        chk_busy(busy, ECYC);
        u_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
        u_prog.read(1'b1, 1'b0, q);
        `CHK(q, LOCK_RST, "lock after erase")
        u_prog.read(1'b0, 1'b0, q);
        `CHK(q, fuse[0], "fuse kept by erase")
        u_prog.load(ACT_CMD, 1'b0, CMD_RD_EEPROM);
        u_prog.load(ACT_ADDR, 1'b0, base);
        u_prog.read(1'b0, 1'b0, q);
        `CHK(q, ERASED_BYTE, "eeprom after erase")
        note("chip erase");
        u_prog.load(ACT_CMD, 1'b0, CMD_RD_SIG);
        for (i = 0; i < 3; i++)
        begin
            u_prog.load(ACT_ADDR, 1'b0, 8'(i));
            u_prog.read(1'b0, 1'b0, q);
            `CHK(q, SIG[i], "signature byte")
        end
        u_prog.load(ACT_ADDR, 1'b0, 8'h00);
        u_prog.read(1'b1, 1'b0, q);
        `CHK(q, CAL, "calibration byte")
        u_prog.load(2'h3, 1'b0, 8'h02);
        u_prog.read(1'b0, 1'b0, q);
        `CHK(q, SIG[0], "idle load ignored")
        `CHK(data_oe, 1'b0, "bus released after read")
        note("signature");
        conclude();
    end
endmodule
